//--- rtl/led_gpio_pin_config.sv
// led select and gpio 8 to 10 configuration register with pin drive
// Behaviour
// - led select chooses link-activity or link roles
// - led select resets to zero, eeprom load sets image
// - usb or lite reset restores image when eeprom present, else zero
// - bits 25:24 select gpio10 function
// - bits 21:20 select gpio9 function
// - bits 17:16 select gpio8 function
// - gpio9 led code follows current led select
// - mirror codes drive internal signal continuously
// - buffer bit set push-pull, clear open-drain
// - direction bit set output, clear input
// - output pins drive written data bit
// - data read returns live pin state
// - events only from pins set as input
// - wake needs input and wake enable
`timescale 1ns/1ps
module led_gpio_pin_config (
	input  wire logic                              ref_clk,
	input  wire logic                              rst,
	input  wire logic                              usb_reset,
	input  wire logic                              lite_reset,
	input  wire logic                              eeprom_present,
	input  wire logic                              eeprom_load,
	input  wire logic                              eeprom_led_function_select,
	input  wire logic [led_gpio_pkg::ADDR_W-1:0]   addr,
	input  wire logic [led_gpio_pkg::DATA_W-1:0]   wdata,
	input  wire logic                              wr_en,
	input  wire logic                              rd_en,
	output logic      [led_gpio_pkg::DATA_W-1:0]   rdata,
	input  wire logic                              speed_led_n,
	input  wire logic                              link_activity_led_n,
	input  wire logic                              link_led_n,
	input  wire logic                              activity_led_n,
	input  wire logic [3:0]                        mii_rxd,
	input  wire logic                              mii_crs,
	input  wire logic                              phy_reset_n_mirror,
	input  wire logic [led_gpio_pkg::NPIN-1:0]     wake_enable,
	input  wire logic [led_gpio_pkg::NPIN-1:0]     pin_in,
	output logic      [led_gpio_pkg::NPIN-1:0]     pin_out,
	output logic      [led_gpio_pkg::NPIN-1:0]     pin_oe,
	output logic      [led_gpio_pkg::NPIN-1:0]     wake_event,
	output logic                                   irq
);
	import led_gpio_pkg::*;

	logic                led_function_select_r;
	logic                led_image_r;
	pin_fn_e             pin10_function_ctl_r;
	pin_fn_e             pin9_function_ctl_r;
	pin_fn_e             pin8_function_ctl_r;
	logic [NPIN-1:0]     pin_buffer_type_r;
	logic [NPIN-1:0]     pin_direction_r;
	logic [NPIN-1:0]     pin_data_r;
	logic [NPIN-1:0]     pin_prev_r;
	logic [NPIN-1:0]     evt_sts_r;
	logic [NPIN-1:0]     evt_mask_r;
	logic [DATA_W-1:0]   rdata_r;
	logic [NPIN-1:0]     wake_r;
	logic                irq_r;

	wire logic              soft_rst;
	wire logic              sel_restore;
	wire logic              cfg_wr;
	wire logic              mask_wr;
	wire logic              sts_rd;
	wire logic [NPIN-1:0]   pin_change;
	wire logic [NPIN-1:0]   evt_set;
	wire logic [NPIN-1:0]   evt_sts_nxt;
	wire logic [NPIN-1:0]   wake_nxt;
	wire logic [DATA_W-1:0] cfg_word;
	wire logic [DATA_W-1:0] rd_word;
	wire logic              irq_nxt;
	wire logic [NPIN-1:0]   mask_nxt;
	wire logic [NPIN-1:0]   led_v;
	wire logic [NPIN-1:0]   mira_v;
	wire logic [NPIN-1:0]   mirb_v;
	wire pin_fn_e           fn_v [NPIN];

	// register decode
	assign cfg_wr  = wr_en && (addr == CFG_OFF);
	assign mask_wr = wr_en && (addr == MASK_OFF);
	assign sts_rd  = rd_en && (addr == STS_OFF);
	assign soft_rst = usb_reset || lite_reset;

	// restore value comes from the eeprom image when one is present, else SEL_RST
	assign sel_restore = eeprom_present ? led_image_r : SEL_RST;

	// reserved positions are never assembled, so they read zero
	assign cfg_word = (DATA_W'(led_function_select_r) << SEL_BIT)
			| (DATA_W'(pin10_function_ctl_r) << CTL10_LSB)
			| (DATA_W'(pin9_function_ctl_r) << CTL9_LSB)
			| (DATA_W'(pin8_function_ctl_r) << CTL8_LSB)
			| (DATA_W'(pin_buffer_type_r) << BUF_LSB)
			| (DATA_W'(pin_direction_r) << DIR_LSB)
			// live pin level, not the stored data
			| (DATA_W'(pin_in) << DATA_LSB);

	assign rd_word = !rd_en ? ZERO_WORD :
			(addr == CFG_OFF) ? cfg_word :
			(addr == STS_OFF) ? DATA_W'(evt_sts_r) :
			(addr == MASK_OFF) ? DATA_W'(evt_mask_r) : ZERO_WORD;

	// changes on pins whose direction bit is set are not events
	assign pin_change = pin_in ^ pin_prev_r;
	assign evt_set    = pin_change & ~pin_direction_r;
	// set wins over the clear of a status read in the same cycle
	assign evt_sts_nxt = (sts_rd ? BITS_RST : evt_sts_r) | evt_set;
	// wake also needs the external wake enable
	assign wake_nxt = evt_set & wake_enable;
	// irq follows the next status and mask, so it never lags a mask write
	assign mask_nxt = mask_wr ? wdata[NPIN-1:0] : evt_mask_r;
	assign irq_nxt  = |(evt_sts_nxt & mask_nxt);

	// pin roles; only the gpio9 led role depends on led select
	assign led_v[P10] = speed_led_n;
	assign led_v[P9]  = led_function_select_r ? link_led_n : link_activity_led_n;
	assign led_v[P8]  = activity_led_n;
	assign mira_v[P10] = mii_rxd[0];
	assign mirb_v[P10] = mii_rxd[3];
	assign mira_v[P9]  = mii_rxd[1];
	assign mirb_v[P9]  = phy_reset_n_mirror;
	assign mira_v[P8]  = mii_rxd[2];
	assign mirb_v[P8]  = mii_crs;
	assign fn_v[P10] = pin10_function_ctl_r;
	assign fn_v[P9]  = pin9_function_ctl_r;
	assign fn_v[P8]  = pin8_function_ctl_r;

	// power reset clears, eeprom load sets image
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			led_image_r           <= SEL_RST;
			led_function_select_r <= SEL_RST;
		end else if (eeprom_load) begin
			led_image_r           <= eeprom_led_function_select;
			led_function_select_r <= eeprom_led_function_select;
		end else if (soft_rst) begin
			led_function_select_r <= sel_restore;
		end else if (cfg_wr) begin
			led_function_select_r <= wdata[SEL_BIT];
		end
	end

	// function fields reset to gpio; soft resets restore them too
	always_ff @(posedge ref_clk) begin
		if (rst || soft_rst) begin
			pin10_function_ctl_r <= CTL_RST;
			pin9_function_ctl_r  <= CTL_RST;
			pin8_function_ctl_r  <= CTL_RST;
			pin_buffer_type_r    <= BITS_RST;
			pin_direction_r      <= BITS_RST;
			pin_data_r           <= BITS_RST;
		end else if (cfg_wr) begin
			pin10_function_ctl_r <= pin_fn_e'(wdata[CTL10_LSB +: CTL_W]);
			pin9_function_ctl_r  <= pin_fn_e'(wdata[CTL9_LSB +: CTL_W]);
			pin8_function_ctl_r  <= pin_fn_e'(wdata[CTL8_LSB +: CTL_W]);
			pin_buffer_type_r    <= wdata[BUF_LSB +: NPIN];
			pin_direction_r      <= wdata[DIR_LSB +: NPIN];
			pin_data_r           <= wdata[DATA_LSB +: NPIN];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			// track the pins in reset, so that release shows no false edge
			pin_prev_r <= pin_in;
			evt_sts_r  <= BITS_RST;
			evt_mask_r <= BITS_RST;
			wake_r     <= BITS_RST;
			irq_r      <= 1'b0;
			rdata_r    <= ZERO_WORD;
		end else begin
			pin_prev_r <= pin_in;
			evt_sts_r  <= evt_sts_nxt;
			evt_mask_r <= mask_nxt;
			wake_r  <= wake_nxt;
			irq_r   <= irq_nxt;
			rdata_r <= rd_word;
		end
	end

	assign rdata      = rdata_r;
	assign wake_event = wake_r;
	assign irq        = irq_r;

	genvar gi;
	generate
		for (gi = 0; gi < NPIN; gi++) begin : g_pin
			pin_drive_cell u_cell (
				.ref_clk   (ref_clk),
				.rst       (rst),
				.fn        (fn_v[gi]),
				.dir_out   (pin_direction_r[gi]),
				.push_pull (pin_buffer_type_r[gi]),
				.data      (pin_data_r[gi]),
				.led_val   (led_v[gi]),
				.mir_a     (mira_v[gi]),
				.mir_b     (mirb_v[gi]),
				.out_r     (pin_out[gi]),
				.oe_r      (pin_oe[gi])
			);
		end
	endgenerate

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	sequence cfg_read_s;
		rd_en && (addr == CFG_OFF);
	endsequence

	sequence soft_only_s;
		soft_rst && !eeprom_load;
	endsequence

	sequence pin9_led_pp_s;
		(pin9_function_ctl_r == FN_LED) && pin_buffer_type_r[P9];
	endsequence

	led_role_map_a: assert property (
		pin9_led_pp_s |=> pin_out[P9] == ($past(led_function_select_r)
			? $past(link_led_n) : $past(link_activity_led_n)))
	else $error("gpio9 led role does not follow led select");

	sel_reset_a: assert property (
		$past(rst) |-> !led_function_select_r && !led_image_r)
	else $error("led select not cleared by reset");

	sel_load_a: assert property (
		eeprom_load |=> led_function_select_r == $past(eeprom_led_function_select))
	else $error("led select not loaded from eeprom");

	soft_restore_a: assert property (
		soft_only_s |=> led_function_select_r ==
			($past(eeprom_present) ? $past(led_image_r) : 1'b0))
	else $error("soft reset did not restore led select");

	ctl_write_a: assert property (
		cfg_wr && !soft_rst |=> pin10_function_ctl_r == $past(wdata[CTL10_LSB +: CTL_W])
			&& pin9_function_ctl_r == $past(wdata[CTL9_LSB +: CTL_W])
			&& pin8_function_ctl_r == $past(wdata[CTL8_LSB +: CTL_W]))
	else $error("function field write lost");

	ctl_reset_a: assert property (
		$past(rst) |-> pin10_function_ctl_r == FN_GPIO
			&& pin9_function_ctl_r == FN_GPIO && pin8_function_ctl_r == FN_GPIO)
	else $error("function fields not gpio after reset");

	crs_mirror_a: assert property (
		(pin8_function_ctl_r == FN_MIR_B) && pin_buffer_type_r[P8]
			|=> pin_oe[P8] && pin_out[P8] == $past(mii_crs))
	else $error("gpio8 does not mirror crs");

	rxd_mirror_a: assert property (
		(pin10_function_ctl_r == FN_MIR_A) && pin_buffer_type_r[P10]
			|=> pin_oe[P10] && pin_out[P10] == $past(mii_rxd[0]))
	else $error("gpio10 does not mirror rxd0");

	led_select_a: assert property (
		(pin10_function_ctl_r == FN_LED) && pin_buffer_type_r[P10]
			|=> pin_out[P10] == $past(speed_led_n))
	else $error("gpio10 led not speed");

	open_drain_a: assert property (
		((pin_oe & pin_out) & ~$past(pin_buffer_type_r)) == BITS_RST)
	else $error("open drain pin driven high");

	dir_input_a: assert property (
		(pin8_function_ctl_r == FN_GPIO) && !pin_direction_r[P8] |=> !pin_oe[P8])
	else $error("input gpio8 is driven");

	gpio_out_a: assert property (
		(pin9_function_ctl_r == FN_GPIO) && pin_direction_r[P9]
			&& pin_buffer_type_r[P9]
			|=> pin_oe[P9] && pin_out[P9] == $past(pin_data_r[P9]))
	else $error("gpio9 output does not drive data bit");

	read_live_a: assert property (
		cfg_read_s |=> rdata[DATA_LSB +: NPIN] == $past(pin_in))
	else $error("data read not live pin state");

	event_gate_a: assert property (
		(wake_event & $past(pin_direction_r)) == BITS_RST)
	else $error("event from output pin");

	wake_gate_a: assert property (
		(wake_event & ~$past(wake_enable)) == BITS_RST)
	else $error("wake from disabled pin");

	reserved_zero_a: assert property (
		cfg_read_s |=> (rdata & RSVD_MASK) == ZERO_WORD)
	else $error("reserved bits read nonzero");

	unmapped_zero_a: assert property (
		rd_en && (addr != CFG_OFF) && (addr != STS_OFF) && (addr != MASK_OFF)
			|=> rdata == ZERO_WORD)
	else $error("unmapped read nonzero");

	irq_level_a: assert property (
		irq == |(evt_sts_r & evt_mask_r))
	else $error("irq does not match unmasked status");

	sts_clear_a: assert property (
		sts_rd |=> (evt_sts_r & ~$past(evt_set)) == BITS_RST)
	else $error("status read did not clear");

	sts_set_a: assert property (
		(|evt_set) |=> (evt_sts_r & $past(evt_set)) == $past(evt_set))
	else $error("pin event lost from status");
endmodule

//--- rtl/led_gpio_pkg.sv
// constants and types shared by the led and gpio pin configuration block
package led_gpio_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int NPIN   = 3;
	localparam int CTL_W  = 2;

	// register byte offsets
	localparam logic [ADDR_W-1:0] CFG_OFF  = 8'h24;
	localparam logic [ADDR_W-1:0] STS_OFF  = 8'h30;
	localparam logic [ADDR_W-1:0] MASK_OFF = 8'h34;

	// field positions inside the configuration word
	localparam int SEL_BIT   = 31;
	localparam int CTL10_LSB = 24;
	localparam int CTL9_LSB  = 20;
	localparam int CTL8_LSB  = 16;
	localparam int BUF_LSB   = 8;
	localparam int DIR_LSB   = 4;
	localparam int DATA_LSB  = 0;

	// pin indices inside the three-bit vectors
	localparam int P8  = 0;
	localparam int P9  = 1;
	localparam int P10 = 2;

	localparam logic [DATA_W-1:0] RSVD_MASK = 32'h7CCCF888;
	localparam logic [NPIN-1:0]   BITS_RST  = 3'h0;
	localparam logic              SEL_RST   = 1'h0;
	localparam logic [DATA_W-1:0] ZERO_WORD = 32'h0;

	// pin function codes: gpio, led, first mirror, second mirror
	typedef enum logic [CTL_W-1:0] {
		FN_GPIO,
		FN_LED,
		FN_MIR_A,
		FN_MIR_B
	} pin_fn_e;

	localparam pin_fn_e CTL_RST = FN_GPIO;
endpackage

//--- rtl/pin_drive_cell.sv
// output value and enable for one configurable pin
`timescale 1ns/1ps
module pin_drive_cell (
	input  wire logic                 ref_clk,
	input  wire logic                 rst,
	input  wire led_gpio_pkg::pin_fn_e fn,
	input  wire logic                 dir_out,
	input  wire logic                 push_pull,
	input  wire logic                 data,
	input  wire logic                 led_val,
	input  wire logic                 mir_a,
	input  wire logic                 mir_b,
	output logic                      out_r,
	output logic                      oe_r
);
	import led_gpio_pkg::*;

	wire logic drive_val;
	wire logic drive_en;
	wire logic out_nxt;
	wire logic oe_nxt;

	assign drive_val = (fn == FN_GPIO) ? data :
			(fn == FN_LED) ? led_val :
			(fn == FN_MIR_A) ? mir_a : mir_b;
	// gpio drives only when set as output
	assign drive_en = (fn != FN_GPIO) || dir_out;
	assign oe_nxt  = drive_en && (push_pull || !drive_val);
	assign out_nxt = push_pull && drive_val;

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			out_r <= 1'b0;
			oe_r  <= 1'b0;
		end else begin
			out_r <= out_nxt;
			oe_r  <= oe_nxt;
		end
	end
endmodule

//--- bench/pin_board.sv
// board model: pull-ups on the three pins plus an optional external driver
`timescale 1ns/1ps
module pin_board (
	input  wire logic [led_gpio_pkg::NPIN-1:0] pin_out,
	input  wire logic [led_gpio_pkg::NPIN-1:0] pin_oe,
	input  wire logic [led_gpio_pkg::NPIN-1:0] ext_en,
	input  wire logic [led_gpio_pkg::NPIN-1:0] ext_val,
	output logic      [led_gpio_pkg::NPIN-1:0] pin_in
);
	import led_gpio_pkg::*;
	// pull-up for open-drain
	// the far driver backs off while the block drives, so no contention is modelled
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val) | (~pin_oe & ~ext_en);
endmodule

//--- bench/testbench.sv
// self-checking bench for the led and gpio pin configuration block
`timescale 1ns/1ps
module testbench;
	import led_gpio_pkg::*;
	logic              ref_clk, rst, usb_reset, lite_reset, irq;
	logic              eeprom_present, eeprom_load, eeprom_led_function_select, wr_en, rd_en;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] wdata, rdata, rv, w;
	logic [9:0]        src;
	logic [2:0]        wake_enable, pin_in, pin_out, pin_oe, wake_event, ext_en, ext_val, wk;
	integer            seed = 32'h1F62;
	int                err_total, tests_run, n;

	led_gpio_pin_config u_dut (
		.ref_clk(ref_clk), .rst(rst), .usb_reset(usb_reset), .lite_reset(lite_reset),
		.eeprom_present(eeprom_present), .eeprom_load(eeprom_load),
		.eeprom_led_function_select(eeprom_led_function_select), .addr(addr), .wdata(wdata), .wr_en(wr_en),
		.rd_en(rd_en), .rdata(rdata), .speed_led_n(src[0]), .link_activity_led_n(src[1]),
		.link_led_n(src[2]), .activity_led_n(src[3]), .mii_rxd(src[7:4]),
		.mii_crs(src[8]), .phy_reset_n_mirror(src[9]), .wake_enable(wake_enable),
		.pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .wake_event(wake_event),
		.irq(irq));

	pin_board u_board (.pin_out(pin_out), .pin_oe(pin_oe), .ext_en(ext_en),
		.ext_val(ext_val), .pin_in(pin_in));

	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	task automatic stop_test;
		$display("counts: %0d compared, %0d mismatched", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic chk_reg(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e) begin
			err_total++;
			$display("unexpected at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	task automatic chk_pin(input logic [5:0] g, input logic [5:0] e);
		tests_run++;
		if (g !== e) begin
			err_total++;
			$display("unexpected at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	task automatic tick(input int k);
		repeat (k) @(posedge ref_clk);
		#1;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		wr_en <= 1'b1;
		addr  <= a;
		wdata <= d;
		@(posedge ref_clk);
		wr_en <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a);
		@(posedge ref_clk);
		rd_en <= 1'b1;
		addr  <= a;
		@(posedge ref_clk);
		rd_en <= 1'b0;
		#1 rv = rdata;
	endtask

	// bounded wait; running out counts as a mismatch and ends the run
	task automatic wait_irq;
		tests_run++;
		for (int i = 0; i < 8; i++) begin
			tick(1);
			if (irq === 1'b1)
				return;
		end
		err_total++;
		stop_test;
	endtask

	// expected {oe, out masked by oe} from the written word and the sources
	function automatic logic [5:0] exp_drive(input logic [31:0] c, input logic [9:0] s);
		logic [2:0] o, e;
		logic [1:0] f;
		logic       v;
		for (int i = 0; i < 3; i++) begin
			f = c[16+4*i +: 2];
			case (f)
				2'h0: v = c[i];
				2'h1: v = (i == 0) ? s[3] : (i == 1) ? (c[31] ? s[2] : s[1]) : s[0];
				2'h2: v = (i == 0) ? s[6] : (i == 1) ? s[5] : s[4];
				default: v = (i == 0) ? s[8] : (i == 1) ? s[9] : s[7];
			endcase
			e[i] = ((f != 2'h0) || c[4+i]) && (c[8+i] || !v);
			o[i] = c[8+i] & v & e[i];
		end
		return {e, o};
	endfunction

	initial begin
		{rst, usb_reset, lite_reset, eeprom_present, eeprom_load} = 5'h10;
		{eeprom_led_function_select, wr_en, rd_en, addr, wdata, src} = '0;
		{wake_enable, ext_en, ext_val} = '0;
		repeat (4) @(posedge ref_clk);
		rst <= 1'b0;
		rd(CFG_OFF);
		chk_reg(rv, {29'h0, pin_in});
		// pins sat still through reset, so release must not raise an event
		rd(STS_OFF);
		chk_reg(rv, 32'h0);
		$display("test reset done");
		@(posedge ref_clk);
		ext_en <= 3'h7;
		for (int i = 0; i < 40; i++) begin
			@(posedge ref_clk);
			src     <= 10'($random(seed));
			ext_val <= 3'($random(seed));
			w = (i < 2) ? {32{i[0]}} : $random(seed);
			wr(CFG_OFF, w);
			tick(1);
			chk_pin({pin_oe, pin_out & pin_oe}, exp_drive(w, src));
			rd(CFG_OFF);
			chk_reg(rv, (w & ~RSVD_MASK & 32'hFFFFFFF8) | {29'h0, pin_in});
		end
		wr(8'h40, 32'hFFFFFFFF);
		rd(8'h40);
		chk_reg(rv, 32'h0);
		rd(CFG_OFF);
		chk_reg(rv, (w & ~RSVD_MASK & 32'hFFFFFFF8) | {29'h0, pin_in});
		$display("test config done");
		@(posedge ref_clk);
		eeprom_led_function_select <= 1'b1;
		eeprom_load    <= 1'b1;
		@(posedge ref_clk);
		eeprom_load <= 1'b0;
		for (int k = 0; k < 3; k++) begin
			@(posedge ref_clk);
			eeprom_present <= (k != 2);
			wr(CFG_OFF, {k == 2, 31'h777});
			@(posedge ref_clk);
			usb_reset  <= (k == 0);
			lite_reset <= (k != 0);
			@(posedge ref_clk);
			usb_reset  <= 1'b0;
			lite_reset <= 1'b0;
			rd(CFG_OFF);
			chk_reg(rv, {k != 2, 28'h0, pin_in});
		end
		$display("test soft reset done");
		@(posedge ref_clk);
		ext_val <= 3'h0;
		tick(3);
		rd(STS_OFF);
		@(posedge ref_clk);
		ext_val <= 3'h4;
		tick(4);
		chk_pin({5'h0, irq}, 6'h0);
		wr(MASK_OFF, 32'h7);
		wait_irq;
		rd(STS_OFF);
		chk_reg(rv, 32'h4);
		tick(3);
		chk_pin({5'h0, irq}, 6'h0);
		@(posedge ref_clk);
		wake_enable <= 3'h2;
		{wk, n} = '0;
		@(posedge ref_clk);
		ext_val <= 3'h7;
		repeat (6) begin
			tick(1);
			wk |= wake_event;
			n += int'(wake_event[1]);
		end
		chk_pin({wk, 3'(n)}, 6'h11);
		rd(STS_OFF);
		chk_reg(rv, 32'h3);
		wr(CFG_OFF, 32'h11);
		tick(2);
		rd(STS_OFF);
		@(posedge ref_clk);
		wake_enable <= 3'h1;
		ext_val     <= 3'h6;
		wk = '0;
		repeat (4) begin
			tick(1);
			wk |= wake_event;
		end
		rd(STS_OFF);
		chk_reg({wk, rv[28:0]}, 32'h0);
		$display("test events done");
		stop_test;
	end

	initial begin
		#200000;
		err_total++;
		stop_test;
	end
endmodule
